// ===== fnvcb_pkg.sv
// package: constants, types and command codes of the persistent configuration bank
package fnvcb_pkg;

   // ==========================================================
   // address map of the persistent_config_space
   localparam logic [7:0] ADDR_BUS_IF    = 8'h00; // bus_interface_mode_cfg
   localparam logic [7:0] ADDR_DUMMY     = 8'h01; // dummy_cycle_count_cfg
   localparam logic [7:0] ADDR_LOCK      = 8'h02; // permanent_lock_bits
   localparam logic [7:0] ADDR_DRIVE     = 8'h03; // output_drive_code_cfg
   localparam logic [7:0] ADDR_CRC       = 8'h04; // transit_check_partition_cfg
   localparam logic [7:0] ADDR_AWIDTH    = 8'h05; // address_width_cfg
   localparam logic [7:0] ADDR_XIP       = 8'h06; // execute_in_place_cfg
   localparam logic [7:0] ADDR_WRAP      = 8'h07; // read_wrap_cfg
   localparam logic [7:0] ADDR_LAST_DEF  = 8'h07; // last defined byte
   localparam int         NUM_DEFINED    = 8;

   // ==========================================================
   // reset values and codes
   localparam logic [7:0] RESERVED_VAL   = 8'hFF;
   localparam logic [7:0] DEF_DUMMY      = 8'h1F;
   localparam logic [7:0] DEF_LOCK       = 8'h90;
   localparam logic [7:0] IOC_SPI_DS     = 8'hFF;
   localparam logic [7:0] IOC_SPI_NODS   = 8'hDF;
   localparam logic [7:0] IOC_ODDR_DS    = 8'hE7;
   localparam logic [7:0] IOC_ODDR_NODS  = 8'hC7;
   localparam logic [7:0] DUMMY_ALT_DEF  = 8'h00;
   localparam logic [7:0] DUMMY_MAX      = 8'h1E;
   localparam logic [7:0] AWIDTH_4BYTE   = 8'hFE;
   localparam logic [7:0] OTP_MASK       = 8'h0F; // sfdp + security 1..3 locks

   localparam logic [7:0] NV_DEFAULT [NUM_DEFINED] = '{
      IOC_SPI_DS, DEF_DUMMY, DEF_LOCK, RESERVED_VAL,
      RESERVED_VAL, RESERVED_VAL, RESERVED_VAL, RESERVED_VAL};

   // ==========================================================
   // flag byte positions
   localparam int FLAG_AMF_BIT   = 0;
   localparam int FLAG_PROTECTED_ACCESS_ERROR_FLAG_BIT  = 1;
   localparam int FLAG_READY_BIT = 7;

   // ==========================================================
   // serial command codes
   localparam logic [7:0] OPC_WREN     = 8'h06;
   localparam logic [7:0] OPC_WR_NV    = 8'hB1;
   localparam logic [7:0] OPC_RD_NV    = 8'hB5;
   localparam logic [7:0] OPC_RD_FLAG  = 8'h70;
   localparam logic [7:0] OPC_CLR_FLAG = 8'h50;
   localparam logic [7:0] OPC_SOFT_RST = 8'h99;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int PROG_TIME_NS  = 1000;
   localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STRAP_WAIT    = 3;

   // ==========================================================
   // types
   typedef struct packed {
      logic [7:0] wrap;
      logic [7:0] xip;
      logic [7:0] awidth;
      logic [7:0] crc;
      logic [7:0] drive;
      logic [7:0] lock;
      logic [7:0] dummy;
      logic [7:0] bus_if;
   } fnvcb_cfg_t;

   typedef enum logic [2:0] {
      ST_OPC, ST_ADDR, ST_WDATA, ST_DUMMY, ST_RDATA, ST_DONE
   } fnvcb_state_t;

endpackage : fnvcb_pkg

// ===== fnvcb_top.sv
// module: persistent configuration bank with its serial command port
// ==========================================================
module fnvcb_top
   import fnvcb_pkg::*;
#(
   parameter logic [7:0] CMD_DEFAULT_DUMMY = 8'h08, // default dummy count for reads
   parameter int         PROG_CYC          = PROG_CYCLES
) (
   input  wire logic       CLK_SYS,      // system clock, 250 MHz
   input  wire logic       RESET_N,      // asynchronous reset, active low
   input  wire logic       SCLK,         // serial link clock from host
   input  wire logic       CS_N,         // chip select, active low
   input  wire logic       SI,           // serial data in
   input  wire logic       VARIANT_ODDR, // factory strap, 1 = octal ddr variant
   output logic            SO,           // serial data out
   output logic            SO_OE_N,      // output enable, low while driving
   output fnvcb_cfg_t      CFG_ACTIVE,   // active configuration set
   output logic [7:0]      DUMMY_CYCLES, // effective dummy count
   output logic            WRITE_ENABLE_LATCH,          // write_enable_latch
   output logic            PROTECTED_ACCESS_ERROR_FLAG,         // protected_access_error_flag
   output logic            BUSY          // persistent write in progress
);

   // ==========================================================
   // synchronisers
   logic       cs_s1, cs_s2, cs_s3;
   logic       sck_s1, sck_s2, sck_s3;
   logic       si_s1, si_s2;
   logic       var_s1, var_s2;
   logic       sck_rise, sck_fall, cs_rise;

   // ==========================================================
   // state
   fnvcb_state_t state_ff;
   logic [7:0]   shift_ff, tx_ff, opc_ff, addr_ff, cnt_ff;
   logic [3:0]   bit_ff;
   logic         so_ff, so_oe_n_ff;
   logic         wr_req_ff, wren_ff, clr_ff, srst_ff;
   logic [7:0]   wr_data_ff;
   logic [7:0]   nv_mem_ff [NUM_DEFINED];
   fnvcb_cfg_t   icfg_ff;
   logic         wel_ff, protected_access_error_flag_ff, busy_ff, load_ff, strap_done_ff, oddr_ff;
   logic [1:0]   strap_cnt_ff;
   logic [15:0]  prog_cnt_ff;
   logic [7:0]   prog_addr_ff, prog_data_ff, dummy_ff;
   logic [7:0]   nxt_dummy, nxt_rd_byte, nxt_flag, nxt_lock;
   logic         addr_defined, ioc_ok;

   // pin inputs pass two flops; edge detect only looks at the second stage on
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         cs_s1  <= 1'b1;
         cs_s2  <= 1'b1;
         cs_s3  <= 1'b1;
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
         si_s1  <= 1'b0;
         si_s2  <= 1'b0;
         var_s1 <= 1'b0;
         var_s2 <= 1'b0;
      end else begin
         cs_s1  <= CS_N;
         cs_s2  <= cs_s1;
         cs_s3  <= cs_s2;
         sck_s1 <= SCLK;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         si_s1  <= SI;
         si_s2  <= si_s1;
         var_s1 <= VARIANT_ODDR;
         var_s2 <= var_s1;
      end
   end

   assign sck_rise = sck_s2 & ~sck_s3 & ~cs_s2;
   assign sck_fall = ~sck_s2 & sck_s3 & ~cs_s2;
   assign cs_rise  = cs_s2 & ~cs_s3;

   // ==========================================================
   // decode helpers
   always_comb begin
      // 00h and 1Fh (and reserved codes) fall back to the command default
      if (icfg_ff.dummy == DUMMY_ALT_DEF || icfg_ff.dummy > DUMMY_MAX) begin
         nxt_dummy = CMD_DEFAULT_DUMMY;
      end else begin
         nxt_dummy = icfg_ff.dummy;
      end
      addr_defined = (addr_ff <= ADDR_LAST_DEF);
      // reserved locations read back FFh
      if (addr_defined) begin
         nxt_rd_byte = nv_mem_ff[addr_ff[2:0]];
      end else begin
         nxt_rd_byte = RESERVED_VAL;
      end
      nxt_flag                 = 8'h00;
      nxt_flag[FLAG_READY_BIT] = ~busy_ff;
      nxt_flag[FLAG_PROTECTED_ACCESS_ERROR_FLAG_BIT]  = protected_access_error_flag_ff;
      nxt_flag[FLAG_AMF_BIT]   = (icfg_ff.awidth == AWIDTH_4BYTE);
      // otp lock bits only ever go from 0 to 1
      nxt_lock = prog_data_ff | (nv_mem_ff[ADDR_LOCK[2:0]] & OTP_MASK);
      // octal ddr variant accepts only its two interface codes
      ioc_ok = !oddr_ff || (wr_data_ff == IOC_ODDR_DS) || (wr_data_ff == IOC_ODDR_NODS);
   end

   // ==========================================================
   // serial frame engine: sample on rising sclk, drive on falling sclk
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         state_ff   <= ST_OPC;
         shift_ff   <= 8'h00;
         tx_ff      <= 8'hFF;
         opc_ff     <= 8'h00;
         addr_ff    <= 8'h00;
         cnt_ff     <= 8'h00;
         bit_ff     <= 4'h0;
         so_ff      <= 1'b0;
         so_oe_n_ff <= 1'b1;
         wr_req_ff  <= 1'b0;
         wren_ff    <= 1'b0;
         clr_ff     <= 1'b0;
         srst_ff    <= 1'b0;
         wr_data_ff <= 8'h00;
      end else begin
         wr_req_ff <= 1'b0;
         wren_ff   <= 1'b0;
         clr_ff    <= 1'b0;
         srst_ff   <= 1'b0;
         if (cs_s2) begin
            // frame end: commands act only when the frame closed cleanly
            if (cs_rise) begin
               if (state_ff == ST_DONE && opc_ff == OPC_WREN) begin
                  wren_ff <= 1'b1;
               end
               if (state_ff == ST_DONE && opc_ff == OPC_CLR_FLAG) begin
                  clr_ff <= 1'b1;
               end
               if (state_ff == ST_DONE && opc_ff == OPC_SOFT_RST) begin
                  srst_ff <= 1'b1;
               end
               if (state_ff == ST_WDATA && bit_ff == 4'd8) begin
                  wr_req_ff  <= 1'b1;
                  wr_data_ff <= shift_ff;
               end
            end
            state_ff   <= ST_OPC;
            bit_ff     <= 4'h0;
            so_oe_n_ff <= 1'b1;
         end else if (sck_rise) begin
            case (state_ff)
               ST_OPC: begin
                  shift_ff <= {shift_ff[6:0], si_s2};
                  bit_ff   <= bit_ff + 4'd1;
                  if (bit_ff == 4'd7) begin
                     opc_ff <= {shift_ff[6:0], si_s2};
                     bit_ff <= 4'h0;
                     if ({shift_ff[6:0], si_s2} == OPC_WR_NV || {shift_ff[6:0], si_s2} == OPC_RD_NV) begin
                        state_ff <= ST_ADDR;
                     end else if ({shift_ff[6:0], si_s2} == OPC_RD_FLAG) begin
                        tx_ff    <= nxt_flag;
                        state_ff <= ST_RDATA;
                     end else begin
                        state_ff <= ST_DONE;
                     end
                  end
               end
               ST_ADDR: begin
                  shift_ff <= {shift_ff[6:0], si_s2};
                  bit_ff   <= bit_ff + 4'd1;
                  if (bit_ff == 4'd7) begin
                     addr_ff  <= {shift_ff[6:0], si_s2};
                     bit_ff   <= 4'h0;
                     cnt_ff   <= 8'h00;
                     state_ff <= (opc_ff == OPC_WR_NV) ? ST_WDATA : ST_DUMMY;
                  end
               end
               ST_WDATA: begin
                  shift_ff <= {shift_ff[6:0], si_s2};
                  // more than eight bits spoils the frame
                  bit_ff   <= (bit_ff == 4'd9) ? bit_ff : bit_ff + 4'd1;
               end
               ST_DUMMY: begin
                  // count dummy clocks after the address, then load the data byte
                  cnt_ff <= cnt_ff + 8'd1;
                  if (cnt_ff == dummy_ff - 8'd1) begin
                     tx_ff    <= nxt_rd_byte;
                     state_ff <= ST_RDATA;
                  end
               end
               default: begin
               end
            endcase
         end else if (sck_fall && state_ff == ST_RDATA) begin
            // single byte, then ones follow for the rest of the frame
            so_ff      <= tx_ff[7];
            tx_ff      <= {tx_ff[6:0], 1'b1};
            so_oe_n_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // strap capture after reset release, latch, error flag and programming
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         strap_cnt_ff  <= 2'd0;
         strap_done_ff <= 1'b0;
         oddr_ff       <= 1'b0;
      end else if (!strap_done_ff) begin
         strap_cnt_ff <= strap_cnt_ff + 2'd1;
         if (strap_cnt_ff == 2'(STRAP_WAIT - 1)) begin
            strap_done_ff <= 1'b1;
            oddr_ff       <= var_s2;
         end
      end
   end

   // write_enable_latch: cleared by a finished or refused write
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         wel_ff <= 1'b0;
      end else if (srst_ff) begin
         wel_ff <= 1'b0;
      end else if (wr_req_ff && wel_ff && !busy_ff && !addr_defined) begin
         wel_ff <= 1'b0;
      end else if (wr_req_ff && wel_ff && !busy_ff && addr_ff == ADDR_BUS_IF && !ioc_ok) begin
         wel_ff <= 1'b0;
      end else if (busy_ff && prog_cnt_ff == 16'd0) begin
         wel_ff <= 1'b0;
      end else if (wren_ff && !busy_ff) begin
         wel_ff <= 1'b1;
      end
   end

   // error flag: a new refusal in the clear cycle still sets it
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         protected_access_error_flag_ff <= 1'b0;
      end else if (wr_req_ff && wel_ff && !busy_ff && !addr_defined) begin
         protected_access_error_flag_ff <= 1'b1;
      end else if (clr_ff || srst_ff) begin
         protected_access_error_flag_ff <= 1'b0;
      end
   end

   // programming timer; the byte lands only when the timer expires
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         busy_ff      <= 1'b0;
         prog_cnt_ff  <= 16'd0;
         prog_addr_ff <= 8'h00;
         prog_data_ff <= 8'h00;
      end else if (busy_ff) begin
         prog_cnt_ff <= prog_cnt_ff - 16'd1;
         if (prog_cnt_ff == 16'd0) begin
            busy_ff <= 1'b0;
         end
      end else if (wr_req_ff && wel_ff && addr_defined && (addr_ff != ADDR_BUS_IF || ioc_ok)) begin
         busy_ff      <= 1'b1;
         prog_cnt_ff  <= 16'(PROG_CYC - 1);
         prog_addr_ff <= addr_ff;
         prog_data_ff <= wr_data_ff;
      end
   end

   // ==========================================================
   // persistent storage; the power-on baseline comes from reset
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         for (int i = 0; i < NUM_DEFINED; i++) begin
            nv_mem_ff[i] <= NV_DEFAULT[i];
         end
      end else if (!strap_done_ff && strap_cnt_ff == 2'(STRAP_WAIT - 1)) begin
         nv_mem_ff[ADDR_BUS_IF[2:0]] <= var_s2 ? IOC_ODDR_DS : IOC_SPI_DS;
      end else if (busy_ff && prog_cnt_ff == 16'd0) begin
         if (prog_addr_ff == ADDR_LOCK) begin
            nv_mem_ff[prog_addr_ff[2:0]] <= nxt_lock;
         end else begin
            nv_mem_ff[prog_addr_ff[2:0]] <= prog_data_ff;
         end
      end
   end

   // ==========================================================
   // active configuration: loaded at reset, lock byte follows at once
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         load_ff <= 1'b1;
      end else if (srst_ff) begin
         load_ff <= 1'b1;
      end else if (strap_done_ff && !busy_ff) begin
         load_ff <= 1'b0;
      end
   end

   // a reload waits out a running write so it never copies a half update
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         icfg_ff <= '{wrap: RESERVED_VAL, xip: RESERVED_VAL, awidth: RESERVED_VAL, crc: RESERVED_VAL,
                      drive: RESERVED_VAL, lock: DEF_LOCK, dummy: DEF_DUMMY, bus_if: IOC_SPI_DS};
      end else if (load_ff && strap_done_ff && !busy_ff) begin
         icfg_ff <= {nv_mem_ff[7], nv_mem_ff[6], nv_mem_ff[5], nv_mem_ff[4],
                     nv_mem_ff[3], nv_mem_ff[2], nv_mem_ff[1], nv_mem_ff[0]};
      end else if (busy_ff && prog_cnt_ff == 16'd0 && prog_addr_ff == ADDR_LOCK) begin
         icfg_ff.lock <= nxt_lock;
      end
   end

   // effective dummy count, registered for the frame engine and the port
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         dummy_ff <= CMD_DEFAULT_DUMMY;
      end else begin
         dummy_ff <= nxt_dummy;
      end
   end

   // ==========================================================
   // outputs, all from flops
   assign SO           = so_ff;
   assign SO_OE_N      = so_oe_n_ff;
   assign CFG_ACTIVE   = icfg_ff;
   assign DUMMY_CYCLES = dummy_ff;
   assign WRITE_ENABLE_LATCH          = wel_ff;
   assign PROTECTED_ACCESS_ERROR_FLAG         = protected_access_error_flag_ff;
   assign BUSY         = busy_ff;

endmodule : fnvcb_top

// ===== fnvcb_top_asserts.sv
// checker: port-level properties of the persistent configuration bank
module fnvcb_top_asserts
   import fnvcb_pkg::*;
#(
   parameter logic [7:0] CMD_DEFAULT_DUMMY = 8'h08 // default read dummy count
) (
   input wire logic       CLK_SYS,      // system clock
   input wire logic       RESET_N,      // async reset, active low
   input wire logic       SCLK,         // link clock
   input wire logic       CS_N,         // chip select, active low
   input wire logic       SI,           // serial data in
   input wire logic       VARIANT_ODDR, // factory strap
   input wire logic       SO,           // serial data out
   input wire logic       SO_OE_N,      // output enable, active low
   input wire fnvcb_cfg_t CFG_ACTIVE,   // active configuration set
   input wire logic [7:0] DUMMY_CYCLES, // effective dummy count
   input wire logic       WRITE_ENABLE_LATCH,          // write_enable_latch
   input wire logic       PROTECTED_ACCESS_ERROR_FLAG,         // protected_access_error_flag
   input wire logic       BUSY          // persistent write running
);
   // =====
   // properties, all in the system clock domain
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);

   a_reset_defaults: assert property ($rose(RESET_N) |-> CFG_ACTIVE[63:8] == 56'hFFFF_FFFF_FF90_1F)
      else $error("active set not at defaults after reset");
   // the strap is synchronised first, so give the reload a few edges
   a_variant_default: assert property ($rose(RESET_N) |-> ##8 CFG_ACTIVE.bus_if == (VARIANT_ODDR ? 8'hE7 : 8'hFF))
      else $error("bus interface default does not follow the strap");
   // stable input first: the count may be one register behind the field
   a_dummy_map: assert property ((CFG_ACTIVE.dummy inside {[8'h01:8'h1E]}) && $stable(CFG_ACTIVE.dummy)
      |-> DUMMY_CYCLES == CFG_ACTIVE.dummy)
      else $error("dummy count differs from configured code");
   a_dummy_default: assert property (!(CFG_ACTIVE.dummy inside {[8'h01:8'h1E]}) && $stable(CFG_ACTIVE.dummy)
      |-> DUMMY_CYCLES == CMD_DEFAULT_DUMMY)
      else $error("default dummy count not used");
   a_lock_sticky: assert property (($past(CFG_ACTIVE.lock[3:0]) & ~CFG_ACTIVE.lock[3:0]) == 4'h0)
      else $error("a permanent lock bit was cleared");
   a_lock_at_write: assert property ($changed(CFG_ACTIVE.lock) |-> $past(BUSY) || $past(BUSY, 2))
      else $error("lock byte changed away from a write end");
   a_protected_access_error_flag_refusal: assert property ($rose(PROTECTED_ACCESS_ERROR_FLAG) |-> ##[0:2] (!WRITE_ENABLE_LATCH && !BUSY))
      else $error("refused write left latch set or started programming");
   a_deferred_fields: assert property ($fell(BUSY) |-> $stable(CFG_ACTIVE[63:24]) && $stable(CFG_ACTIVE[15:0]))
      else $error("deferred field changed at write end");

   c_refusal: cover property ($rose(PROTECTED_ACCESS_ERROR_FLAG));
   c_lock_update: cover property ($changed(CFG_ACTIVE.lock));
   c_write_end: cover property ($fell(BUSY));
   c_long_dummy: cover property (DUMMY_CYCLES == 8'h1E);
endmodule : fnvcb_top_asserts

bind fnvcb_top fnvcb_top_asserts #(.CMD_DEFAULT_DUMMY(CMD_DEFAULT_DUMMY)) chk_u (
   .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .SCLK(SCLK), .CS_N(CS_N), .SI(SI),
   .VARIANT_ODDR(VARIANT_ODDR), .SO(SO), .SO_OE_N(SO_OE_N), .CFG_ACTIVE(CFG_ACTIVE),
   .DUMMY_CYCLES(DUMMY_CYCLES), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .PROTECTED_ACCESS_ERROR_FLAG(PROTECTED_ACCESS_ERROR_FLAG), .BUSY(BUSY));

// ===== fnvcb_host_model.sv
// partner: host controller issuing frames on the serial command port
module fnvcb_host_model #(
   parameter int HALF = 10 // system clocks per link half period (40 ns)
) (
   input  wire logic clk,    // system clock
   output logic      sclk,   // link clock, still outside frames
   output logic      cs_n,   // chip select, active low
   output logic      si,     // serial data to device
   input  wire logic so,     // serial data from device
   input  wire logic so_oe_n // low while device drives so
);
   // =====
   // idle levels from time zero
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // =====
   // one frame: ntx bits msb first, ndum dummy clocks, nrx reply bits
   task automatic frame(input logic [23:0] tx, input int ntx, input int ndum, input int nrx,
                        output logic [7:0] rx);
      int i;
      rx = 8'h00;
      @(negedge clk);
      cs_n = 1'b0;
      for (i = ntx + ndum + nrx - 1; i >= 0; i--) begin
         // past the command the line means nothing, so it keeps toggling
         if (i >= ndum + nrx)
            si = tx[i - ndum - nrx];
         else
            si = ~si;
         repeat (HALF) @(negedge clk);
         sclk = 1'b1;
         // a reply bit only counts while the device drives the line
         if (i < nrx)
            rx[i] = (so_oe_n === 1'b0) ? so : 1'bx;
         repeat (HALF) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (HALF) @(negedge clk);
      cs_n = 1'b1;
      si   = ~si;
      repeat (HALF) @(negedge clk);
   endtask : frame
endmodule : fnvcb_host_model

// ===== fnvcb_bench.sv
// bench: frame-level tests of the persistent configuration bank
module fnvcb_bench
   import fnvcb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [63:0] DEF = 64'hFFFF_FFFF_FF90_1FFF;
   // rows: wrap, xip, awidth, crc, drive, (lock), dummy, bus_if
   localparam logic [63:0] ROWS [5] = '{
      64'hFFFF_FFFF_FF00_1FFF, 64'hFEFE_FEF8_FD00_04DF, 64'hFDFD_FFFA_0F00_00E7,
      64'hFCF8_FEFC_0D00_1EC7, 64'hFFFF_FFFE_0C00_01FF};

   logic       CLK_SYS, RESET_N, SCLK, CS_N, SI, VARIANT_ODDR, SO, SO_OE_N, WRITE_ENABLE_LATCH, PROTECTED_ACCESS_ERROR_FLAG, BUSY;
   fnvcb_cfg_t CFG_ACTIVE;
   logic [7:0] DUMMY_CYCLES;
   logic [7:0] rd;
   int         miscompares = 0;
   int         checks_done = 0;
   int         exp_dummy   = 8;

   // =====
   // clock and instances
   initial begin
      CLK_SYS = 1'b0;
      forever #2 CLK_SYS = ~CLK_SYS;
   end

   fnvcb_top #(.PROG_CYC(20)) dut_u (
      .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .SCLK(SCLK), .CS_N(CS_N), .SI(SI),
      .VARIANT_ODDR(VARIANT_ODDR), .SO(SO), .SO_OE_N(SO_OE_N), .CFG_ACTIVE(CFG_ACTIVE),
      .DUMMY_CYCLES(DUMMY_CYCLES), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .PROTECTED_ACCESS_ERROR_FLAG(PROTECTED_ACCESS_ERROR_FLAG), .BUSY(BUSY));

   fnvcb_host_model host_u (
      .clk(CLK_SYS), .sclk(SCLK), .cs_n(CS_N), .si(SI), .so(SO), .so_oe_n(SO_OE_N));

   // =====
   // tasks
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   // reset also stands in for power-up, so the persistent bytes return to defaults
   task automatic do_reset();
      @(negedge CLK_SYS);
      RESET_N = 1'b0;
      repeat (3) @(negedge CLK_SYS);
      RESET_N = 1'b1;
      repeat (12) @(negedge CLK_SYS); // no frame before the strap capture and reload
      exp_dummy = 8;
   endtask : do_reset

   task automatic cmd(input logic [7:0] op);
      host_u.frame({16'h0000, op}, 8, 0, 0, rd);
   endtask : cmd

   task automatic flag_rd(output logic [7:0] r);
      host_u.frame({16'h0000, OPC_RD_FLAG}, 8, 0, 8, r);
   endtask : flag_rd

   task automatic cfg_rd(input logic [7:0] a, output logic [7:0] d);
      host_u.frame({8'h00, OPC_RD_NV, a}, 16, exp_dummy, 8, d);
   endtask : cfg_rd

   task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      int         n;
      cmd(OPC_WREN);
      host_u.frame({OPC_WR_NV, a, d}, 24, 0, 0, r);
      for (n = 0; n < 8 && r[FLAG_READY_BIT] !== 1'b1; n++)
         flag_rd(r);
      check(r[FLAG_READY_BIT], 1'b1);
   endtask : cfg_wr

   // =====
   // test sequence
   initial begin : main
      int          i;
      int          j;
      logic [63:0] row;
      logic [63:0] prev;
      RESET_N      = 1'b0;
      VARIANT_ODDR = 1'b0;
      do_reset();
      check(CFG_ACTIVE, DEF);
      check(DUMMY_CYCLES, 8'h08);
      check({WRITE_ENABLE_LATCH, PROTECTED_ACCESS_ERROR_FLAG, BUSY, SO_OE_N}, 4'b0001);
      for (i = 0; i < 10; i++) begin
         cfg_rd((i < 9) ? 8'(i) : 8'hFF, rd);
         check(rd, (i < 8) ? DEF[i*8 +: 8] : 8'hFF);
      end
      $display("test reset_defaults done");
      // reserved bytes refuse the write, raise the flag and drop the latch
      for (i = 0; i < 2; i++) begin
         cfg_wr(i ? 8'hFF : 8'h08, 8'h55);
         check({PROTECTED_ACCESS_ERROR_FLAG, WRITE_ENABLE_LATCH, BUSY}, 3'b100);
         cfg_rd(i ? 8'hFF : 8'h08, rd);
         check(rd, 8'hFF);
         flag_rd(rd);
         check(rd[FLAG_PROTECTED_ACCESS_ERROR_FLAG_BIT], 1'b1);
         cmd(OPC_CLR_FLAG);
         check(PROTECTED_ACCESS_ERROR_FLAG, 1'b0);
      end
      $display("test reserved_write done");
      cfg_wr(ADDR_LOCK, 8'h91);
      check(CFG_ACTIVE.lock, 8'h91);
      cfg_wr(ADDR_LOCK, 8'h90);
      check(CFG_ACTIVE.lock, 8'h91);
      $display("test lock_bits done");
      // every code but the lock byte is stored, held back, then applied by a soft reset
      for (i = 0; i < 5; i++) begin
         row  = ROWS[i];
         prev = CFG_ACTIVE;
         for (j = 0; j < 8; j++)
            if (j != 2)
               cfg_wr(8'(j), row[j*8 +: 8]);
         check(CFG_ACTIVE, prev);
         cmd(OPC_SOFT_RST);
         check(CFG_ACTIVE, {row[63:24], 8'h91, row[15:0]});
         exp_dummy = (row[15:8] inside {[8'h01:8'h1E]}) ? int'(row[15:8]) : 8;
         check(DUMMY_CYCLES, 8'(exp_dummy));
         cfg_rd(ADDR_WRAP, rd);
         check(rd, row[63:56]);
         flag_rd(rd);
         check(rd[FLAG_AMF_BIT], row[47:40] == 8'hFE);
      end
      $display("test code_table done");
      VARIANT_ODDR = 1'b1;
      do_reset();
      check(CFG_ACTIVE, {DEF[63:8], 8'hE7});
      cfg_rd(ADDR_BUS_IF, rd);
      check(rd, 8'hE7);
      // a write without the latch is dropped silently
      host_u.frame({OPC_WR_NV, ADDR_WRAP, 8'h00}, 24, 0, 0, rd);
      check({PROTECTED_ACCESS_ERROR_FLAG, WRITE_ENABLE_LATCH, BUSY}, 3'b000);
      cfg_rd(ADDR_WRAP, rd);
      check(rd, RESERVED_VAL);
      // the octal variant keeps its interface byte within its own two codes
      cmd(OPC_WREN);
      check(WRITE_ENABLE_LATCH, 1'b1);
      host_u.frame({OPC_WR_NV, ADDR_BUS_IF, IOC_ODDR_NODS}, 24, 0, 0, rd);
      check(BUSY, 1'b1);
      flag_rd(rd);
      check(rd, 8'h80);
      cfg_rd(ADDR_BUS_IF, rd);
      check(rd, IOC_ODDR_NODS);
      cfg_wr(ADDR_BUS_IF, IOC_SPI_DS);
      check({PROTECTED_ACCESS_ERROR_FLAG, WRITE_ENABLE_LATCH, BUSY}, 3'b000);
      cfg_rd(ADDR_BUS_IF, rd);
      check(rd, IOC_ODDR_NODS);
      $display("test variant_default done");
      finish_test();
   end

   // watchdog: the tests need about 60000 cycles, so this leaves margin under the run cap
   initial begin : watchdog
      repeat (90000) @(posedge CLK_SYS);
      miscompares++;
      finish_test();
   end
endmodule : fnvcb_bench
